// [logic/i2cck_pkg.sv]
// Package for the serial bit-clock and interrupt-flag block.
// Assumes a single 20 MHz reference clock and no register bus.
`default_nettype none
package i2cck_pkg;
   // Reference clock period in ns.
   localparam int I2CCK_REF_PERIOD_NS = 50;
   // Divider and data widths.
   localparam int I2CCK_DIV_W = 16;
   localparam int I2CCK_BYTE_W = 8;
   // Reset values of the divider bytes and of the data buffer.
   localparam logic [7:0] I2CCK_DIV_BYTE_RST = 8'h00;
   localparam logic [7:0] I2CCK_DATA_RST = 8'h00;
   // Least divider value the generator will count with.
   localparam logic [15:0] I2CCK_DIV_MIN = 16'h0002;
   // Clock source select codes.
   localparam logic [1:0] I2CCK_SRC_SUB_MAIN = 2'h2;
   localparam logic [1:0] I2CCK_SRC_SUB_MAIN_ALT = 2'h3;
   // Clock generator states.
   typedef enum logic [1:0] {
      I2CCK_IDLE = 2'b00,
      I2CCK_LOW = 2'b01,
      I2CCK_WAIT = 2'b10,
      I2CCK_HIGH = 2'b11
   } i2cck_state_t;
   // Half of the divider: (div)/2 for even, (div-1)/2 for odd, at least one.
   function automatic logic [15:0] i2cck_half(input logic [15:0] div);
      logic [15:0] h;
      h = {1'b0, div[15:1]};
      i2cck_half = (h == 16'h0000) ? 16'h0001 : h;
   endfunction
endpackage
`default_nettype wire

// [logic/i2cck_buf2.sv]
// Two-entry buffer carrying received bytes to the receive holding register.
// Assumes the shared clock, enable and asynchronous active-low reset.
`default_nettype none
module i2cck_buf2
   import i2cck_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);
   logic [7:0] mem_r [2];
   logic [7:0] mem_nxt [2];
   logic rd_r, rd_nxt, wr_r, wr_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////
   // Pointers wrap over two slots; count gives honest full and empty.
   always_comb begin
      push = in_valid && (cnt_r != 2'h2);
      pop = (cnt_r != 2'h0) && out_ready;
      mem_nxt = mem_r;
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      if (push) begin
         mem_nxt[wr_r] = in_data;
         wr_nxt = ~wr_r;
      end
      if (pop) begin
         rd_nxt = ~rd_r;
      end
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_r <= '{I2CCK_DATA_RST, I2CCK_DATA_RST};
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         cnt_r <= 2'h0;
      end else if (ce) begin
         mem_r <= mem_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rd_r];
endmodule
`default_nettype wire

// [logic/i2cck_top.sv]
// Bit-clock generator, clock stretch observation, sub-main clock request
// and interrupt flags of a two-wire serial interface.
// Assumes all inputs synchronous to REF_CLK; SCL is open drain.
`default_nettype none
//
// Operation
// (RULE_01) Master uses generator; slave ignores source select.
// (RULE_02) Bit clock is source over 16-bit divider.
// (RULE_03) Software keeps divider at least four/eight.
// (RULE_04) High and low minimum are half divider.
// (RULE_05) Software meets bus low/high minimum times.
// (RULE_06) Low starts on any low; high waits release.
// (RULE_07) Status shows SCL held low by others.
// (RULE_08) Status also shows own stretching.
// (RULE_09) Status may pulse at rising SCL edges.
// (RULE_10) Request sub-main clock until block idle.
// (RULE_11) No automatic request for auxiliary clock.
// (RULE_12) Slave needs no internal clock; data irqs wake.
// (RULE_13) Two irq lines, per-flag and global enable.
// (RULE_14) Tx-ready and rx-full drive DMA triggers.
// (RULE_15) Tx-ready set when free; cleared by write/NACK.
// (RULE_16) Soft reset holds tx-ready, clears tx enable.
// (RULE_17) Rx-full set on load, cleared on read.
// (RULE_18) Arbitration loss sets flag, drops master select.
// (RULE_19) No-ack flag set on missing ack; START clears.
// (RULE_20) Slave start-addressed flag; STOP clears.
// (RULE_21) Slave stop-detected flag; START clears.
// (RULE_22) Lines merge companion rx and tx flags.
// (RULE_23) Multi-master clear disables own-address compare.
module i2cck_top
   import i2cck_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic POWER_UP_CLEAR,
   input wire logic SOFT_RESET_HOLD,
   input wire logic I2C_MODE,
   input wire logic MASTER_SET,
   input wire logic MULTI_MASTER_SELECT,
   input wire logic [1:0] CLOCK_SOURCE_SELECT,
   input wire logic [7:0] DIVIDER_BYTE_LOW,
   input wire logic [7:0] DIVIDER_BYTE_HIGH,
   input wire logic DIVIDER_INPUT_CLOCK,
   input wire logic SCL_RUN,
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE,
   input wire logic TX_WRITE,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_LOAD,
   output logic [7:0] TX_SHIFT_DATA,
   input wire logic RX_VALID,
   output logic RX_READY,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_READ,
   output logic [7:0] RX_HOLDING_BUFFER,
   input wire logic ACK_MISSING,
   input wire logic ARB_LOST,
   input wire logic START_SEEN,
   input wire logic STOP_SEEN,
   input wire logic OWN_ADDR_MATCH,
   input wire logic BUSY,
   input wire logic TX_IRQ_ENABLE,
   input wire logic RX_IRQ_ENABLE,
   input wire logic [3:0] STATE_IRQ_ENABLE,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic COMPANION_RX_FLAG,
   input wire logic COMPANION_TX_FLAG,
   output logic MASTER_SELECT,
   output logic ADDR_COMPARE_EN,
   output logic SCL_HELD_LOW_STATUS,
   output logic SUB_MAIN_CLOCK_REQ,
   output logic TX_READY_FLAG,
   output logic RX_FULL_FLAG,
   output logic ARB_LOST_FLAG,
   output logic NO_ACK_FLAG,
   output logic START_ADDRESSED_FLAG,
   output logic STOP_DETECTED_FLAG,
   output logic DMA_TX_TRIG,
   output logic DMA_RX_TRIG,
   output logic IRQ_DATA,
   output logic IRQ_STATE
);
   // Clear from power-up or soft reset; soft reset only while held.
   logic clr;
   assign clr = POWER_UP_CLEAR || SOFT_RESET_HOLD;

   ////////////////////////////////////////////////////////////////////////
   // Bit-clock generator. Counts divider-input ticks; a tick is the clock
   // source selected outside, sampled as a one-cycle enable.
   i2cck_state_t st_r, st_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic drive_low_r, drive_low_nxt;
   logic [15:0] div, half;
   logic stretch;

   always_comb begin
      div = {DIVIDER_BYTE_HIGH, DIVIDER_BYTE_LOW}; // [RULE_02]
      half = i2cck_half((div < I2CCK_DIV_MIN) ? I2CCK_DIV_MIN : div); // [RULE_04]
      stretch = (TX_READY_FLAG && !TX_WRITE && BUSY) || (RX_FULL_FLAG && BUSY);
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      drive_low_nxt = drive_low_r;
      if (clr || !MASTER_SELECT || !SCL_RUN) begin
         // Slave mode leaves the generator and source select unused.
         st_nxt = I2CCK_IDLE; // [RULE_01]
         cnt_nxt = 16'h0000;
         // A slave holds SCL low too while its buffers wait on software.
         drive_low_nxt = stretch && !clr;
      end else begin
         unique case (st_r)
            I2CCK_IDLE: begin
               st_nxt = I2CCK_LOW;
               cnt_nxt = 16'h0000;
               drive_low_nxt = 1'b1;
            end
            I2CCK_LOW: begin
               cnt_nxt = DIVIDER_INPUT_CLOCK ? cnt_r + 16'h0001 : cnt_r;
               if (DIVIDER_INPUT_CLOCK && (cnt_r + 16'h0001 >= half) && !stretch) begin
                  st_nxt = I2CCK_WAIT; // Released; wait for the wire.
                  drive_low_nxt = 1'b0;
               end
            end
            I2CCK_WAIT: begin
               if (SCL_I) begin // [RULE_06]
                  st_nxt = I2CCK_HIGH;
                  cnt_nxt = 16'h0000;
               end
            end
            I2CCK_HIGH: begin
               cnt_nxt = DIVIDER_INPUT_CLOCK ? cnt_r + 16'h0001 : cnt_r;
               // Another device pulling low cuts our high short.
               if (!SCL_I || (DIVIDER_INPUT_CLOCK && (cnt_r + 16'h0001 >= half))) begin
                  st_nxt = I2CCK_LOW; // [RULE_06]
                  cnt_nxt = 16'h0000;
                  drive_low_nxt = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= I2CCK_IDLE;
         cnt_r <= 16'h0000;
         drive_low_r <= 1'b0;
      end else if (CE) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         drive_low_r <= drive_low_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive path with a two-entry buffer so a late read loses no byte.
   logic buf_valid, buf_ready, buf_pop;
   logic [7:0] buf_data;
   logic [7:0] rxh_r, rxh_nxt;
   logic rxf_r, rxf_nxt;

   i2cck_buf2 u_rxbuf (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .ce(CE),
      .in_valid(RX_VALID),
      .in_ready(buf_ready),
      .in_data(RX_DATA),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(buf_data)
   );

   always_comb begin
      buf_pop = buf_valid && (!rxf_r || RX_READ) && !clr;
      rxh_nxt = buf_pop ? buf_data : rxh_r;
      // Load wins over a same-cycle read; a clear beats both.
      rxf_nxt = !clr && (buf_pop || (rxf_r && !RX_READ)); // [RULE_17]
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags and master select. Flag sets win over the automatic clears; arbitration loss beats MASTER_SET.
   logic txr_r, txr_nxt, mst_r, mst_nxt;
   logic al_r, al_nxt, na_r, na_nxt, sa_r, sa_nxt, sp_r, sp_nxt;
   logic [7:0] txd_r, txd_nxt;

   always_comb begin
      txd_nxt = TX_WRITE ? TX_DATA : txd_r;
      txr_nxt = txr_r;
      if (clr) begin
         txr_nxt = I2C_MODE; // [RULE_16]
      end else if (TX_LOAD) begin
         txr_nxt = 1'b1; // Buffer moved to shifter, room again. [RULE_15]
      end else if (TX_WRITE || ACK_MISSING) begin
         txr_nxt = 1'b0; // [RULE_15]
      end
      mst_nxt = !clr && !ARB_LOST && (mst_r || MASTER_SET)
                && !(mst_r && OWN_ADDR_MATCH && MULTI_MASTER_SELECT); // [RULE_18]
      al_nxt = !clr && (al_r || ARB_LOST || (mst_r && OWN_ADDR_MATCH
               && MULTI_MASTER_SELECT)); // [RULE_18]
      na_nxt = !clr && (ACK_MISSING || (na_r && !START_SEEN)); // [RULE_19]
      sa_nxt = !clr && ((!mst_r && START_SEEN && OWN_ADDR_MATCH) // [RULE_20]
               || (sa_r && !STOP_SEEN));
      sp_nxt = !clr && ((!mst_r && STOP_SEEN) || (sp_r && !START_SEEN)); // [RULE_21]
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rxh_r <= I2CCK_DATA_RST;
         rxf_r <= 1'b0;
         txd_r <= I2CCK_DATA_RST;
         txr_r <= 1'b0;
         mst_r <= 1'b0;
         al_r <= 1'b0;
         na_r <= 1'b0;
         sa_r <= 1'b0;
         sp_r <= 1'b0;
      end else if (CE) begin
         rxh_r <= rxh_nxt;
         rxf_r <= rxf_nxt;
         txd_r <= txd_nxt;
         txr_r <= txr_nxt;
         mst_r <= mst_nxt;
         al_r <= al_nxt;
         na_r <= na_nxt;
         sa_r <= sa_nxt;
         sp_r <= sp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs: status, clock request, irq lines and triggers.
   logic sts_nxt, req_nxt, irqd_nxt, irqs_nxt, txie_eff, rxie_eff, smsrc;
   logic [3:0] st_flags;

   always_comb begin
      // Released by us yet low on the wire, or stretching ourselves;
      // the wire lags our release, so a short pulse at rising edges is normal.
      sts_nxt = (mst_r && !drive_low_r && !SCL_I)
                || (drive_low_r && stretch); // [RULE_07] [RULE_08] [RULE_09]
      // Only the sub-main source codes raise a request; auxiliary never does.
      smsrc = (CLOCK_SOURCE_SELECT == I2CCK_SRC_SUB_MAIN)
              || (CLOCK_SOURCE_SELECT == I2CCK_SRC_SUB_MAIN_ALT); // [RULE_11]
      req_nxt = !clr && mst_r && smsrc && (BUSY || st_r != I2CCK_IDLE); // [RULE_10] [RULE_12]
      txie_eff = TX_IRQ_ENABLE && !clr; // [RULE_16]
      rxie_eff = RX_IRQ_ENABLE && !clr; // [RULE_17]
      st_flags = {sp_nxt, sa_nxt, na_nxt, al_nxt};
      irqd_nxt = GLOBAL_IRQ_ENABLE && ((txr_nxt && txie_eff) || (rxf_nxt && rxie_eff)
                 || COMPANION_TX_FLAG); // [RULE_13] [RULE_22]
      irqs_nxt = GLOBAL_IRQ_ENABLE && (|(st_flags & STATE_IRQ_ENABLE)
                 || COMPANION_RX_FLAG); // [RULE_13] [RULE_22]
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SCL_O <= 1'b0;
         SCL_OE <= 1'b0;
         SCL_HELD_LOW_STATUS <= 1'b0;
         SUB_MAIN_CLOCK_REQ <= 1'b0;
         IRQ_DATA <= 1'b0;
         IRQ_STATE <= 1'b0;
         DMA_TX_TRIG <= 1'b0;
         DMA_RX_TRIG <= 1'b0;
         TX_READY_FLAG <= 1'b0;
         RX_FULL_FLAG <= 1'b0;
         ARB_LOST_FLAG <= 1'b0;
         NO_ACK_FLAG <= 1'b0;
         START_ADDRESSED_FLAG <= 1'b0;
         STOP_DETECTED_FLAG <= 1'b0;
         MASTER_SELECT <= 1'b0;
         ADDR_COMPARE_EN <= 1'b0;
         RX_READY <= 1'b0;
         RX_HOLDING_BUFFER <= I2CCK_DATA_RST;
         TX_SHIFT_DATA <= I2CCK_DATA_RST;
      end else if (CE) begin
         SCL_O <= 1'b0;
         SCL_OE <= drive_low_nxt; // Open drain: enable means pull low.
         SCL_HELD_LOW_STATUS <= sts_nxt;
         SUB_MAIN_CLOCK_REQ <= req_nxt;
         IRQ_DATA <= irqd_nxt;
         IRQ_STATE <= irqs_nxt;
         DMA_TX_TRIG <= txr_nxt; // [RULE_14]
         DMA_RX_TRIG <= rxf_nxt; // [RULE_14]
         TX_READY_FLAG <= txr_nxt;
         RX_FULL_FLAG <= rxf_nxt;
         ARB_LOST_FLAG <= al_nxt;
         NO_ACK_FLAG <= na_nxt;
         START_ADDRESSED_FLAG <= sa_nxt;
         STOP_DETECTED_FLAG <= sp_nxt;
         MASTER_SELECT <= mst_nxt;
         ADDR_COMPARE_EN <= MULTI_MASTER_SELECT; // [RULE_23]
         RX_READY <= buf_ready;
         RX_HOLDING_BUFFER <= rxh_nxt;
         TX_SHIFT_DATA <= txd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the flags and the generator.
   sequence s_wait_release;
      (st_r == I2CCK_WAIT) && !SCL_I;
   endsequence

   AST_TX_CLEAR: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_15]
      CE && TX_WRITE && !TX_LOAD && !clr |=> !TX_READY_FLAG)
      else $error("Tx-ready not cleared by write.");
   AST_TX_HOLD: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_16]
      CE && SOFT_RESET_HOLD && I2C_MODE |=> TX_READY_FLAG)
      else $error("Tx-ready not held in soft reset.");
   AST_RX_CLEAR: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_17]
      CE && clr |=> !RX_FULL_FLAG)
      else $error("Rx-full survived clear.");
   AST_ARB: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_18]
      CE && ARB_LOST && !clr |=> ARB_LOST_FLAG && !MASTER_SELECT)
      else $error("Arbitration loss mishandled.");
   AST_NACK: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_19]
      CE && START_SEEN && !ACK_MISSING |=> !NO_ACK_FLAG)
      else $error("No-ack not cleared by start.");
   AST_STOP: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_21]
      CE && !clr && !mst_r && STOP_SEEN |=> STOP_DETECTED_FLAG)
      else $error("Stop flag not set.");
   AST_SADDR: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_20]
      CE && STOP_SEEN && !START_SEEN |=> !START_ADDRESSED_FLAG)
      else $error("Start-addressed not cleared by stop.");
   AST_WAIT: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_06]
      (CE && MASTER_SELECT && SCL_RUN && !clr) and s_wait_release |=> st_r != I2CCK_HIGH)
      else $error("High started before release.");
   AST_DMA: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_14]
      DMA_TX_TRIG == TX_READY_FLAG && DMA_RX_TRIG == RX_FULL_FLAG)
      else $error("DMA trigger mismatch.");
   AST_MM: assert property (@(posedge REF_CLK) disable iff (!RST_B) // [RULE_23]
      CE && !MULTI_MASTER_SELECT |=> !ADDR_COMPARE_EN)
      else $error("Compare enabled in single master.");
endmodule
`default_nettype wire

// [tb/i2cck_far_end.sv]
// Far-side model of the SCL wire: a slave that may stretch the clock.
// Assumes the design pulls SCL low only through its output enable.
`default_nettype none
module i2cck_far_end (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_oe,
   input wire logic [7:0] stretch,
   output logic scl_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic oe_r;
   logic pull;
   logic [7:0] cnt_r;
   ////////////////////////////////////////////////////////////////////////
   // Start the stretch in the very cycle the design lets go, so no glitch high escapes.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oe_r <= 1'b0;
         cnt_r <= 8'h00;
      end else begin
         oe_r <= scl_oe;
         if (oe_r && !scl_oe && stretch != 8'h00) begin
            cnt_r <= stretch - 8'h01;
         end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
   // Wired AND with a pull-up: the longest low period wins.
   assign pull = (cnt_r != 8'h00) || (oe_r && !scl_oe && stretch != 8'h00);
   assign scl_line = ~(scl_oe | pull);
endmodule
`default_nettype wire

// [tb/i2cck_top_bench.sv]
// Self-checking bench of the bit-clock and interrupt-flag block.
// Assumes the package, the design and the far-end SCL model are compiled first.
`default_nettype none
module i2cck_top_bench
   import i2cck_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic REF_CLK, RST_B, CE, POWER_UP_CLEAR, SOFT_RESET_HOLD, I2C_MODE, MASTER_SET;
   logic MULTI_MASTER_SELECT, DIVIDER_INPUT_CLOCK, SCL_RUN, TX_WRITE, TX_LOAD, RX_VALID;
   logic RX_READ, ACK_MISSING, ARB_LOST, START_SEEN, STOP_SEEN, OWN_ADDR_MATCH, BUSY;
   logic TX_IRQ_ENABLE, RX_IRQ_ENABLE, GLOBAL_IRQ_ENABLE, COMPANION_RX_FLAG, COMPANION_TX_FLAG;
   logic [1:0] CLOCK_SOURCE_SELECT;
   logic [3:0] STATE_IRQ_ENABLE;
   logic [7:0] DIVIDER_BYTE_LOW, DIVIDER_BYTE_HIGH, TX_DATA, RX_DATA;
   logic [7:0] TX_SHIFT_DATA, RX_HOLDING_BUFFER, stretch;
   logic SCL_O, SCL_OE, MASTER_SELECT, ADDR_COMPARE_EN, SCL_HELD_LOW_STATUS, SUB_MAIN_CLOCK_REQ;
   logic TX_READY_FLAG, RX_FULL_FLAG, ARB_LOST_FLAG, NO_ACK_FLAG, START_ADDRESSED_FLAG;
   logic STOP_DETECTED_FLAG, DMA_TX_TRIG, DMA_RX_TRIG, IRQ_DATA, IRQ_STATE, RX_READY;
   wire logic SCL_I;
   int bad_count, compares, cycles, n, len, h;
   // Flag rows: events {nack,arb,start,stop,own}, state enables, flags {stop,addr,nack,arb}.
   localparam logic [12:0] ROWS [6] = '{13'h1022, 13'h024A, 13'h0544, 13'h0288, 13'h04F0,
      13'h0811};

   i2cck_top i2cck_top_inst (.*);
   i2cck_far_end i2cck_far_end_inst (.clk(REF_CLK), .rst_b(RST_B), .scl_oe(SCL_OE),
      .stretch(stretch), .scl_line(SCL_I));

   ////////////////////////////////////////////////////////////////////////
   // Clock and a cycle ceiling well above the two hundred or so cycles the run needs.
   initial REF_CLK = 1'b0;
   always #25 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared compare, wait and transfer tasks.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(negedge REF_CLK);
   endtask
   task automatic ev(input logic [4:0] e);
      {ACK_MISSING, ARB_LOST, START_SEEN, STOP_SEEN, OWN_ADDR_MATCH} = e;
      step(1);
      {ACK_MISSING, ARB_LOST, START_SEEN, STOP_SEEN, OWN_ADDR_MATCH} = 5'h00;
      step(3);
   endtask
   task automatic pulse_read();
      RX_READ = 1'b1;
      step(1);
      RX_READ = 1'b0;
      step(3);
   endtask
   // Valid waits up to 50 cycles for ready seen high, since ready lags the buffer by one cycle.
   task automatic rx_send(input logic [7:0] d);
      n = 0;
      while (RX_READY !== 1'b1 && n < 50) begin
         step(1);
         n++;
      end
      RX_DATA = d;
      RX_VALID = 1'b1;
      step(1);
      RX_VALID = 1'b0;
      RX_DATA = ~d;
      step(3);
   endtask
   task automatic wait_oe(input logic lvl);
      n = 0;
      while (SCL_OE !== lvl && n < 200) begin
         step(1);
         n++;
      end
      chk(n < 200, 1'b1);
   endtask
   task automatic final_report();
      $display("mismatches %0d, comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, tx-ready cases, table of flag cases, then hand-written awkward cases.
   initial begin
      {CE, POWER_UP_CLEAR, SOFT_RESET_HOLD, I2C_MODE, MASTER_SET, MULTI_MASTER_SELECT} = '0;
      {DIVIDER_INPUT_CLOCK, SCL_RUN, TX_WRITE, TX_LOAD, RX_VALID, RX_READ, BUSY} = '0;
      {TX_IRQ_ENABLE, RX_IRQ_ENABLE, GLOBAL_IRQ_ENABLE, COMPANION_RX_FLAG} = '0;
      {COMPANION_TX_FLAG, ACK_MISSING, ARB_LOST, START_SEEN, STOP_SEEN, OWN_ADDR_MATCH} = '0;
      {CLOCK_SOURCE_SELECT, STATE_IRQ_ENABLE, DIVIDER_BYTE_LOW, DIVIDER_BYTE_HIGH} = '0;
      {TX_DATA, RX_DATA, stretch} = '0;
      RST_B = 1'b0;
      CE = 1'b1;
      step(2);
      chk({TX_READY_FLAG, RX_FULL_FLAG, IRQ_DATA}, 3'h0);
      step(2);
      RST_B = 1'b1;
      I2C_MODE = 1'b1;
      SOFT_RESET_HOLD = 1'b1;
      TX_IRQ_ENABLE = 1'b1;
      GLOBAL_IRQ_ENABLE = 1'b1;
      step(3);
      chk({TX_READY_FLAG, IRQ_DATA}, 2'h2);
      SOFT_RESET_HOLD = 1'b0;
      step(3);
      chk({TX_READY_FLAG, DMA_TX_TRIG, IRQ_DATA}, 3'h7);
      TX_DATA = 8'hA5;
      TX_WRITE = 1'b1;
      step(1);
      TX_WRITE = 1'b0;
      TX_DATA = 8'h5A;
      step(3);
      chk({TX_READY_FLAG, DMA_TX_TRIG, IRQ_DATA}, 3'h0);
      TX_LOAD = 1'b1;
      step(1);
      TX_LOAD = 1'b0;
      step(3);
      chk({TX_READY_FLAG, TX_SHIFT_DATA}, 9'h1A5);
      ev(5'h10);
      chk({TX_READY_FLAG, NO_ACK_FLAG}, 2'h1);
      COMPANION_TX_FLAG = 1'b1;
      step(3);
      chk(IRQ_DATA, 1'b1);
      COMPANION_TX_FLAG = 1'b0;
      TX_LOAD = 1'b1;
      step(1);
      TX_LOAD = 1'b0;
      GLOBAL_IRQ_ENABLE = 1'b0;
      step(3);
      chk({TX_READY_FLAG, IRQ_DATA}, 2'h2);
      GLOBAL_IRQ_ENABLE = 1'b1;
      TX_IRQ_ENABLE = 1'b0;
      // State-change flags in slave mode, and the enable gating of their line.
      for (int i = 0; i < 6; i++) begin
         STATE_IRQ_ENABLE = ROWS[i][7:4];
         ev(ROWS[i][12:8]);
         chk({STOP_DETECTED_FLAG, START_ADDRESSED_FLAG, NO_ACK_FLAG, ARB_LOST_FLAG},
            ROWS[i][3:0]);
         chk(IRQ_STATE, |(ROWS[i][7:4] & ROWS[i][3:0]));
      end
      STATE_IRQ_ENABLE = 4'h0;
      COMPANION_RX_FLAG = 1'b1;
      step(3);
      chk(IRQ_STATE, 1'b1);
      COMPANION_RX_FLAG = 1'b0;
      // Fill the receive path until it refuses while software stalls, then drain it.
      RX_IRQ_ENABLE = 1'b1;
      BUSY = 1'b1;
      rx_send(8'hA0);
      chk({RX_FULL_FLAG, DMA_RX_TRIG, IRQ_DATA, RX_HOLDING_BUFFER}, 11'h7A0);
      rx_send(8'hB1);
      rx_send(8'hC2);
      chk({RX_READY, SCL_HELD_LOW_STATUS, RX_HOLDING_BUFFER}, 10'h1A0);
      RX_DATA = 8'hD3;
      RX_VALID = 1'b1;
      step(1);
      RX_VALID = 1'b0;
      pulse_read();
      chk({RX_FULL_FLAG, RX_HOLDING_BUFFER}, 9'h1B1);
      pulse_read();
      chk({RX_FULL_FLAG, RX_HOLDING_BUFFER}, 9'h1C2);
      pulse_read();
      chk({RX_FULL_FLAG, DMA_RX_TRIG, IRQ_DATA, RX_READY}, 4'h1);
      BUSY = 1'b0;
      // Master generator: divider set to eight, then seven, with multi-master selected.
      DIVIDER_BYTE_LOW = 8'h08;
      DIVIDER_INPUT_CLOCK = 1'b1;
      CLOCK_SOURCE_SELECT = I2CCK_SRC_SUB_MAIN;
      MULTI_MASTER_SELECT = 1'b1;
      MASTER_SET = 1'b1;
      step(1);
      MASTER_SET = 1'b0;
      step(3);
      chk({MASTER_SELECT, ADDR_COMPARE_EN}, 2'h3);
      SCL_RUN = 1'b1;
      for (int k = 0; k < 2; k++) begin
         h = int'(DIVIDER_BYTE_LOW) / 2;
         wait_oe(1'b1);
         len = 0;
         while (SCL_OE === 1'b1 && len < 100) begin
            step(1);
            len++;
         end
         chk(len >= h && len <= h + 1, 1'b1);
         DIVIDER_BYTE_LOW = 8'h07;
         wait_oe(1'b1);
         wait_oe(1'b0);
      end
      for (int s = 0; s < 4; s++) begin
         CLOCK_SOURCE_SELECT = 2'(s);
         step(3);
         chk(SUB_MAIN_CLOCK_REQ, CLOCK_SOURCE_SELECT == I2CCK_SRC_SUB_MAIN ||
            CLOCK_SOURCE_SELECT == I2CCK_SRC_SUB_MAIN_ALT);
      end
      // A slow slave holds SCL low after the design releases it.
      stretch = 8'h14;
      wait_oe(1'b1);
      wait_oe(1'b0);
      step(5);
      chk({SCL_OE, SCL_O, SCL_I, SCL_HELD_LOW_STATUS}, 4'h1);
      n = 0;
      while (SCL_I !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      chk(n >= 10 && n < 100, 1'b1);
      step(2);
      chk(SCL_OE, 1'b0);
      stretch = 8'h00;
      ev(5'h08);
      chk({MASTER_SELECT, ARB_LOST_FLAG}, 2'h1);
      MULTI_MASTER_SELECT = 1'b0;
      SCL_RUN = 1'b0;
      CLOCK_SOURCE_SELECT = I2CCK_SRC_SUB_MAIN;
      step(10);
      chk({ADDR_COMPARE_EN, SUB_MAIN_CLOCK_REQ, SCL_OE}, 3'h0);
      CE = 1'b0; // All state must hold while the enable is low.
      ev(5'h10);
      chk(NO_ACK_FLAG, 1'b0);
      CE = 1'b1;
      POWER_UP_CLEAR = 1'b1;
      step(3);
      chk({ARB_LOST_FLAG, NO_ACK_FLAG, RX_FULL_FLAG, IRQ_STATE}, 4'h0);
      POWER_UP_CLEAR = 1'b0;
      final_report();
   end
endmodule
`default_nettype wire
